// File: logic/upd_regs.vh
// Notes on behaviour
// - interrupt enables written by command c2, read by c3, each with data.
// - interrupt enable access always carries four data bytes after the code.
// - usb bus reset leaves every interrupt enable bit as programmed.
// - bits 23..10 gate endpoints 14..1, bit 9 control in, bit 8 control out.
// - bits 6..0 gate short packet, pseudo frame, frame, end, suspend, resume, reset.
// - dma setup written by f0 and read by f1 with two data bytes.
// - usb bus reset clears only the dma go bit, bit 3.
// - with bit 15 set, end of transfer is raised when the counter reaches zero.
// - with bit 14 set, short or empty out packet raises end of transfer.
// - bits 7..4 select the endpoint that dma serves.
// - writing go starts dma, writing zero stops it, reading shows state.
// - burst field selects 1, 4, 8 or 16 byte request length.
// - f2 loads the byte count, f3 returns remaining bytes, two data bytes each.
// - down counter reloads from programmed count whenever dma is enabled again.
// - usb bus reset leaves the programmed byte count unchanged.
// - command f6 without data resets the controller like the reset pin.
// - buffer writes use codes 01..0f, buffer reads 10 and 12..1f.
// - buffer command resets pointer, each access advances two bytes, m plus one words.
// - dma skips the two byte length word and starts at payload.
// - dma reading a buffer finds its last byte from the length word.
// - bulk and interrupt in data goes to host when buffer full, at end of transfer or on usb bus reset.
// - external end of transfer sends the current buffer, full or not.
`ifndef UPD_REGS_VH
`define UPD_REGS_VH

// ==========================================
// command codes
`define UPD_CMD_IE_WR 8'hc2
`define UPD_CMD_IE_RD 8'hc3
`define UPD_CMD_CFG_WR 8'hf0
`define UPD_CMD_CFG_RD 8'hf1
`define UPD_CMD_CNT_WR 8'hf2
`define UPD_CMD_CNT_RD 8'hf3
`define UPD_CMD_SOFT_RST 8'hf6
`define UPD_CMD_BUFWR_LO 8'h01
`define UPD_CMD_BUFWR_HI 8'h0f
`define UPD_CMD_BUFRD_LO 8'h10
`define UPD_CMD_BUFRD_GAP 8'h11
`define UPD_CMD_BUFRD_HI 8'h1f

// ==========================================
// data phase lengths in bytes
`define UPD_IE_BYTES 6'h04
`define UPD_CFG_BYTES 6'h02

// ==========================================
// dma setup field positions
`define UPD_CFG_COUNT_ZERO_END_SELECT 15
`define UPD_CFG_SHORT_PACKET_END_SELECT 14
`define UPD_CFG_EP_HI 7
`define UPD_CFG_EP_LO 4
`define UPD_CFG_GO 3
`define UPD_CFG_BURST_HI 1
`define UPD_CFG_BURST_LO 0

// ==========================================
// interrupt enable field positions
`define UPD_IE_EP_HI 23
`define UPD_IE_EP_LO 8
`define UPD_IE_BUS_HI 6
`define UPD_IE_BUS_LO 0

// ==========================================
// writable masks and reset values
`define UPD_IE_WMASK 32'h00ffff7f
`define UPD_CFG_WMASK 16'hc0fb
`define UPD_IE_RST 32'h00000000
`define UPD_CFG_RST 16'h0000
`define UPD_CNT_RST 16'h0000

// ==========================================
// buffer geometry: n bytes per endpoint, m plus one words per access
`define UPD_EP_BYTES 6'h20
`define UPD_EP_WORDS 6'h11
`define UPD_FIFO_DEPTH 32
`define UPD_FIFO_WIDTH 8

`endif

// File: logic/upd_core.v
`timescale 1ns/100ps
`include "upd_regs.vh"

// ==========================================
// byte fifo between the dma port and the endpoint buffer
module upd_fifo #(
    parameter W = 8,
    parameter D = 32,
    parameter AW = 5
) (
    input wire clk,              // system clock
    input wire rst_n,            // async reset, active low
    input wire clr,              // synchronous flush
    input wire in_valid,         // push request
    output wire in_ready,        // room available
    input wire [W-1:0] in_data,  // push data
    output wire out_valid,       // data available
    input wire out_ready,        // pop request
    output wire [W-1:0] out_data // head of queue
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_ready && out_valid;

    // storage has no reset; only pointers need a defined state
    always @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // pointers and occupancy
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (clr) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ==========================================
// command interpreter, dma control and endpoint buffer
module upd_core (
    input wire sys_clk,             // 125 mhz system clock
    input wire rst_n,               // async hardware reset, active low
    input wire usb_bus_rst,         // usb bus reset seen, level
    input wire cmd_stb,             // command code strobe, pulse
    input wire [7:0] cmd_code,      // command code
    input wire wr_stb,              // data phase write strobe, pulse
    input wire [15:0] wr_data,      // write data, registers use low byte
    input wire rd_stb,              // data phase read strobe, pulse
    output reg [15:0] rd_data_q,    // read data, valid after rd_stb edge
    input wire [15:0] ep_is_in,     // endpoint direction per buffer index
    input wire out_pkt_valid,       // selected out buffer holds a packet
    input wire [15:0] ep_evt,       // endpoint events, index order
    input wire [6:0] bus_evt,       // bus events, enable bit order
    input wire dma_ack,             // dma byte moved this cycle
    input wire [7:0] dma_wdata,     // byte from dma into an in buffer
    input wire dma_eot_ext,         // external end of transfer, pulse
    output reg dma_req_q,           // dma request
    output reg [7:0] dma_rdata_q,   // byte to dma from an out buffer
    output reg transfer_end_q,      // end of transfer, pulse
    output reg buf_handoff_q,       // buffer sent or released, pulse
    output reg [15:0] ep_irq_q,     // gated endpoint interrupts
    output reg [6:0] bus_irq_q      // gated bus interrupts
);
    localparam W_FILL = 1'b0;
    localparam W_LEN = 1'b1;

    reg [31:0] irq_source_enables_q;
    reg [15:0] dma_setup_q;
    reg [15:0] dma_byte_count_q;    // programmed count
    reg [15:0] dma_count_value_q;   // running down counter
    reg [7:0] cmd_q;
    reg [5:0] phase_q;
    reg [7:0] shadow_q;
    reg [5:0] dptr_q;               // dma byte pointer inside buffer
    reg [7:0] lo_q;
    reg wst_q;
    reg flush_q;
    reg rd_wait_q;
    reg sp_pend_q;
    reg ostage_v_q;
    reg [4:0] burst_cnt_q;
    reg gap_q;
    reg [15:0] buf_mem [0:511];

    reg mem_we;
    reg [8:0] mem_wa;
    reg [15:0] mem_wd;
    reg [4:0] burst_len;
    reg [5:0] end_b;

    wire srst = cmd_stb && (cmd_code == `UPD_CMD_SOFT_RST);
    wire is_bufwr = (cmd_q >= `UPD_CMD_BUFWR_LO) && (cmd_q <= `UPD_CMD_BUFWR_HI);
    wire is_bufrd = (cmd_q >= `UPD_CMD_BUFRD_LO) && (cmd_q <= `UPD_CMD_BUFRD_HI)
                    && (cmd_q != `UPD_CMD_BUFRD_GAP);
    wire [3:0] ep_sel = dma_setup_q[`UPD_CFG_EP_HI:`UPD_CFG_EP_LO];
    wire dma_go = dma_setup_q[`UPD_CFG_GO];
    wire dir_in = ep_is_in[ep_sel];
    wire cpu_in_range = (phase_q < `UPD_EP_WORDS);
    wire cpu_wr = is_bufwr && wr_stb && cpu_in_range;
    wire [15:0] cfg_new = {wr_data[7:0], shadow_q} & `UPD_CFG_WMASK;
    wire cfg_commit = wr_stb && (cmd_q == `UPD_CMD_CFG_WR) && (phase_q == 6'h01);
    wire cnt_commit = wr_stb && (cmd_q == `UPD_CMD_CNT_WR) && (phase_q == 6'h01);
    wire go_rise = cfg_commit && cfg_new[`UPD_CFG_GO] && !dma_go;
    wire [15:0] pkt_len = buf_mem[{ep_sel, 5'h00}];
    wire [15:0] rd_word = buf_mem[{ep_sel, dptr_q[5:1]}];
    wire [31:0] ie_wmask = `UPD_IE_WMASK; // sliced per byte lane

    // fifo hookup; direction picks which side fills and which drains
    wire f_in_ready;
    wire f_out_valid;
    wire [7:0] f_out_data;
    wire byte_moved = dma_ack && dma_req_q && (dir_in ? f_in_ready : ostage_v_q);
    wire rd_active = !dir_in && dma_go && out_pkt_valid && !rd_wait_q;
    wire rd_empty_pkt = (dptr_q == end_b);
    wire rd_push = rd_active && !rd_empty_pkt && f_in_ready;
    wire rd_last = rd_active && (rd_empty_pkt || (rd_push && (dptr_q + 6'h01 == end_b)));
    wire stage_load = !dir_in && (!ostage_v_q || byte_moved);
    wire wr_pop = dir_in && (dma_go || flush_q) && (wst_q == W_FILL) && f_out_valid && !cpu_wr;
    wire len_wr = dir_in && (wst_q == W_LEN) && !cpu_wr;
    wire cnt_eot = byte_moved && dma_setup_q[`UPD_CFG_COUNT_ZERO_END_SELECT] && (dma_count_value_q == 16'h0001);
    wire sp_eot = sp_pend_q && !f_out_valid && !ostage_v_q;
    wire ext_eot = dma_eot_ext && dma_go;
    wire eot_any = cnt_eot || sp_eot || ext_eot;

    upd_fifo #(
        .W(`UPD_FIFO_WIDTH),
        .D(`UPD_FIFO_DEPTH),
        .AW(5)
    ) u_fifo (
        .clk(sys_clk),
        .rst_n(rst_n),
        .clr(srst || go_rise),
        .in_valid(dir_in ? (dma_ack && dma_req_q) : rd_push),
        .in_ready(f_in_ready),
        .in_data(dir_in ? dma_wdata : (dptr_q[0] ? rd_word[15:8] : rd_word[7:0])),
        .out_valid(f_out_valid),
        .out_ready(dir_in ? wr_pop : stage_load),
        .out_data(f_out_data)
    );

    // burst length decode and out packet end pointer
    always @* begin
        case (dma_setup_q[`UPD_CFG_BURST_HI:`UPD_CFG_BURST_LO])
            2'b00: burst_len = 5'h01;
            2'b01: burst_len = 5'h04;
            2'b10: burst_len = 5'h08;
            default: burst_len = 5'h10;
        endcase
        // a packet longer than the buffer is clipped so the pointer stays inside it
        if (pkt_len < {10'h000, `UPD_EP_BYTES}) begin
            end_b = pkt_len[5:0] + 6'h02;
        end else begin
            end_b = `UPD_EP_BYTES + 6'h02;
        end
    end

    // single buffer write port; the cpu wins and dma writes wait one cycle
    always @* begin
        mem_we = 1'b0;
        mem_wa = 9'h000;
        mem_wd = 16'h0000;
        if (cpu_wr) begin
            mem_we = 1'b1;
            mem_wa = {cmd_q[3:0], phase_q[4:0]};
            mem_wd = wr_data;
        end else if (wr_pop) begin
            mem_we = 1'b1;
            mem_wa = {ep_sel, dptr_q[5:1]};
            mem_wd = dptr_q[0] ? {f_out_data, lo_q} : {8'h00, f_out_data};
        end else if (len_wr) begin
            mem_we = 1'b1;
            mem_wa = {ep_sel, 5'h00};
            mem_wd = {10'h000, dptr_q - 6'h02};
        end
    end

    always @(posedge sys_clk) begin
        if (mem_we) begin
            buf_mem[mem_wa] <= mem_wd;
        end
    end

    // ==========================================
    // command port: code latch, data phases, register storage
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= 8'h00;
            phase_q <= 6'h00;
            shadow_q <= 8'h00;
            rd_data_q <= 16'h0000;
            irq_source_enables_q <= `UPD_IE_RST;
            dma_setup_q <= `UPD_CFG_RST;
            dma_byte_count_q <= `UPD_CNT_RST;
            dma_count_value_q <= `UPD_CNT_RST;
        end else if (srst) begin
            cmd_q <= 8'h00;
            phase_q <= 6'h00;
            shadow_q <= 8'h00;
            rd_data_q <= 16'h0000;
            irq_source_enables_q <= `UPD_IE_RST;
            dma_setup_q <= `UPD_CFG_RST;
            dma_byte_count_q <= `UPD_CNT_RST;
            dma_count_value_q <= `UPD_CNT_RST;
        end else begin
            if (cmd_stb) begin
                cmd_q <= cmd_code;
                phase_q <= 6'h00;
            end else if ((wr_stb || rd_stb) && (phase_q != 6'h3f)) begin
                phase_q <= phase_q + 6'h01;
            end
            // interrupt enables take each byte as it arrives, extra bytes ignored
            if (wr_stb && (cmd_q == `UPD_CMD_IE_WR) && (phase_q < `UPD_IE_BYTES)) begin
                case (phase_q[1:0])
                    2'b00: irq_source_enables_q[7:0] <= wr_data[7:0] & ie_wmask[7:0];
                    2'b01: irq_source_enables_q[15:8] <= wr_data[7:0];
                    2'b10: irq_source_enables_q[23:16] <= wr_data[7:0];
                    default: irq_source_enables_q[31:24] <= 8'h00;
                endcase
            end
            // two byte registers commit on the high byte so go acts once
            if (wr_stb && (phase_q == 6'h00)) begin
                shadow_q <= wr_data[7:0];
            end
            if (cfg_commit) begin
                dma_setup_q <= cfg_new;
            end
            if (cnt_commit) begin
                dma_byte_count_q <= {wr_data[7:0], shadow_q};
            end
            if (go_rise) begin
                dma_count_value_q <= dma_byte_count_q;
            end else if (byte_moved && (dma_count_value_q != 16'h0000)) begin
                dma_count_value_q <= dma_count_value_q - 16'h0001;
            end
            // hardware stops win over a host write in the same cycle
            if (usb_bus_rst) begin
                dma_setup_q[`UPD_CFG_GO] <= 1'b0;
            end else if (eot_any) begin
                dma_setup_q[`UPD_CFG_GO] <= 1'b0;
            end
            // read data answers one cycle after the strobe
            if (rd_stb) begin
                case (cmd_q)
                    `UPD_CMD_IE_RD: begin
                        case (phase_q)
                            6'h00: rd_data_q <= {8'h00, irq_source_enables_q[7:0]};
                            6'h01: rd_data_q <= {8'h00, irq_source_enables_q[15:8]};
                            6'h02: rd_data_q <= {8'h00, irq_source_enables_q[23:16]};
                            6'h03: rd_data_q <= {8'h00, irq_source_enables_q[31:24]};
                            default: rd_data_q <= 16'h0000;
                        endcase
                    end
                    `UPD_CMD_CFG_RD: begin
                        rd_data_q <= {8'h00, phase_q[0] ? dma_setup_q[15:8] : dma_setup_q[7:0]};
                    end
                    `UPD_CMD_CNT_RD: begin
                        rd_data_q <= {8'h00, phase_q[0] ? dma_count_value_q[15:8] : dma_count_value_q[7:0]};
                    end
                    default: begin
                        if (is_bufrd && cpu_in_range) begin
                            rd_data_q <= buf_mem[{cmd_q[3:0], phase_q[4:0]}];
                        end else begin
                            rd_data_q <= 16'h0000;
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================
    // dma engine: pointer, packing, hand-off and end of transfer
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dptr_q <= 6'h02;
            lo_q <= 8'h00;
            wst_q <= W_FILL;
            flush_q <= 1'b0;
            rd_wait_q <= 1'b0;
            sp_pend_q <= 1'b0;
            buf_handoff_q <= 1'b0;
            transfer_end_q <= 1'b0;
        end else if (srst || go_rise) begin
            dptr_q <= 6'h02;
            lo_q <= 8'h00;
            wst_q <= W_FILL;
            flush_q <= 1'b0;
            rd_wait_q <= 1'b0;
            sp_pend_q <= 1'b0;
            buf_handoff_q <= 1'b0;
            transfer_end_q <= 1'b0;
        end else begin
            buf_handoff_q <= 1'b0;
            transfer_end_q <= eot_any;
            if (!out_pkt_valid) begin
                rd_wait_q <= 1'b0;
            end
            if (sp_eot) begin
                sp_pend_q <= 1'b0;
            end
            case (wst_q)
                W_FILL: begin
                    if (wr_pop) begin
                        lo_q <= f_out_data;
                        dptr_q <= dptr_q + 6'h01;
                        if (dptr_q == `UPD_EP_BYTES + 6'h01) begin
                            wst_q <= W_LEN;
                        end
                    end else if (dir_in && flush_q && !f_out_valid && !cpu_wr) begin
                        wst_q <= W_LEN;
                    end
                    if (rd_push) begin
                        dptr_q <= dptr_q + 6'h01;
                    end
                    if (rd_last) begin
                        dptr_q <= 6'h02;
                        rd_wait_q <= 1'b1;
                        buf_handoff_q <= 1'b1;
                        if (dma_setup_q[`UPD_CFG_SHORT_PACKET_END_SELECT] && (pkt_len < {10'h000, `UPD_EP_BYTES})) begin
                            sp_pend_q <= 1'b1;
                        end
                    end
                end
                W_LEN: begin
                    if (len_wr) begin
                        buf_handoff_q <= 1'b1;
                        dptr_q <= 6'h02;
                        flush_q <= 1'b0;
                        wst_q <= W_FILL;
                    end
                end
                default: begin
                    wst_q <= W_FILL;
                end
            endcase
            // an in transfer stopped by end of transfer or bus reset still drains and sends; set wins over the hand-off clear
            if (dir_in && (ext_eot || cnt_eot || usb_bus_rst) && dma_go) begin
                flush_q <= 1'b1;
            end
        end
    end

    // ==========================================
    // dma request with burst gaps and output byte stage
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_req_q <= 1'b0;
            dma_rdata_q <= 8'h00;
            ostage_v_q <= 1'b0;
            burst_cnt_q <= 5'h00;
            gap_q <= 1'b0;
        end else if (srst || go_rise) begin
            dma_req_q <= 1'b0;
            dma_rdata_q <= 8'h00;
            ostage_v_q <= 1'b0;
            burst_cnt_q <= 5'h00;
            gap_q <= 1'b0;
        end else begin
            gap_q <= 1'b0;
            if (stage_load) begin
                ostage_v_q <= f_out_valid;
                if (f_out_valid) begin
                    dma_rdata_q <= f_out_data;
                end
            end
            // two idle request cycles between bursts let the controller rearbitrate
            if (byte_moved) begin
                if (burst_cnt_q + 5'h01 == burst_len) begin
                    burst_cnt_q <= 5'h00;
                    gap_q <= 1'b1;
                end else begin
                    burst_cnt_q <= burst_cnt_q + 5'h01;
                end
            end
            dma_req_q <= dma_go && !eot_any && !usb_bus_rst && !gap_q && !(byte_moved
                         && (burst_cnt_q + 5'h01 == burst_len))
                         && (dir_in ? f_in_ready : (stage_load ? f_out_valid : ostage_v_q));
        end
    end

    // interrupt gating; own end of transfer feeds its enable bits
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ep_irq_q <= 16'h0000;
            bus_irq_q <= 7'h00;
        end else if (srst) begin
            ep_irq_q <= 16'h0000;
            bus_irq_q <= 7'h00;
        end else begin
            ep_irq_q <= ep_evt & irq_source_enables_q[`UPD_IE_EP_HI:`UPD_IE_EP_LO];
            bus_irq_q <= (bus_evt | {sp_eot, 2'b00, eot_any, 3'b000})
                         & irq_source_enables_q[`UPD_IE_BUS_HI:`UPD_IE_BUS_LO];
        end
    end
endmodule

// File: verif/upd_core_monitor.sv
`timescale 1ns/100ps
// ==========================================
// port level checks beside the command block
module upd_core_monitor (
    input wire sys_clk, // clock
    input wire rst_n, // reset, active low
    input wire usb_bus_rst, // usb bus reset
    input wire cmd_stb, // code strobe
    input wire [7:0] cmd_code, // code
    input wire rd_stb, // read strobe
    input wire [15:0] rd_data_q, // read data
    input wire [15:0] ep_evt, // endpoint events
    input wire [6:0] bus_evt, // bus events
    input wire dma_eot_ext, // external end
    input wire dma_req_q, // dma request
    input wire transfer_end_q, // end pulse
    input wire [15:0] ep_irq_q, // endpoint irqs
    input wire [6:0] bus_irq_q // bus irqs
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // steps that open a check
    sequence s_bus_rst_held;
        usb_bus_rst ##1 usb_bus_rst;
    endsequence
    sequence s_soft_rst;
        cmd_stb && cmd_code == 8'hf6;
    endsequence
    a_ep_gate: assert property ((ep_irq_q & ~$past(ep_evt)) == 16'h0000)
        else $error("endpoint irq without its event");
    // bits 3 and 6 also carry the block's own end events, so they are left out
    a_bus_gate: assert property ((bus_irq_q & 7'h37 & ~$past(bus_evt)) == 7'h00)
        else $error("bus irq without its event");
    a_bus_rst_stop: assert property (s_bus_rst_held |=> !dma_req_q)
        else $error("dma request survives bus reset");
    a_reset_quiet: assert property ($rose(rst_n) |-> !dma_req_q && !transfer_end_q)
        else $error("outputs active after reset");
    a_soft_rst: assert property (s_soft_rst |=> !dma_req_q && !transfer_end_q && ep_irq_q == 16'h0000)
        else $error("soft reset left state behind");
    a_end_pulse: assert property (transfer_end_q |=> !transfer_end_q)
        else $error("end of transfer longer than one cycle");
    a_end_stops: assert property (transfer_end_q |-> ##[0:2] !dma_req_q)
        else $error("dma still requesting after end");
    a_eot_stops: assert property (dma_eot_ext && dma_req_q |-> ##[1:3] !dma_req_q)
        else $error("external end did not stop dma");
    a_rd_hold: assert property (!rd_stb && !(cmd_stb && cmd_code == 8'hf6) |=> $stable(rd_data_q))
        else $error("read data moved without a read");
endmodule

// File: verif/upd_dma_model.sv
`timescale 1ns/100ps
// ==========================================
// external dma controller, acks each request unless held
module upd_dma_model (
    input wire sys_clk, // clock
    input wire rst_n, // reset, active low
    input wire hold, // stall the transfer
    input wire dma_req_q, // request from block
    output reg dma_ack, // byte moved
    output reg [7:0] dma_wdata // byte into in buffer
);
    // data changes every cycle so a stale byte is never mistaken for a fresh one
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_ack <= 1'b0;
            dma_wdata <= 8'h00;
        end else begin
            dma_ack <= dma_req_q && !hold;
            dma_wdata <= dma_wdata + 8'h01;
        end
    end
endmodule

// File: verif/upd_core_tb.sv
`timescale 1ns/100ps
// ==========================================
// bench for the command block
module upd_core_tb;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    reg usb_bus_rst = 1'b0;
    reg cmd_stb = 1'b0;
    reg [7:0] cmd_code = 8'h00;
    reg wr_stb = 1'b0;
    reg [15:0] wr_data = 16'h0000;
    reg rd_stb = 1'b0;
    reg [15:0] ep_evt = 16'hffff;
    reg [6:0] bus_evt = 7'h7f;
    reg dma_eot_ext = 1'b0;
    reg hold = 1'b0;
    reg [15:0] ep_is_in = 16'hffff;
    reg out_pkt_valid = 1'b0;
    wire [15:0] rd_data_q;
    wire [15:0] ep_irq_q;
    wire [6:0] bus_irq_q;
    wire [7:0] dma_wdata, dma_rdata_q;
    wire dma_ack, dma_req_q, transfer_end_q, buf_handoff_q;
    integer errors = 0, compares = 0, acks = 0, hands = 0;
    // directions and out packets are set by the scenarios
    upd_core uut (.sys_clk, .rst_n, .usb_bus_rst, .cmd_stb, .cmd_code, .wr_stb, .wr_data, .rd_stb, .rd_data_q,
        .ep_is_in, .out_pkt_valid, .ep_evt, .bus_evt, .dma_ack, .dma_wdata, .dma_eot_ext,
        .dma_req_q, .dma_rdata_q, .transfer_end_q, .buf_handoff_q, .ep_irq_q, .bus_irq_q);
    upd_dma_model dma (.sys_clk, .rst_n, .hold, .dma_req_q, .dma_ack, .dma_wdata);
    initial forever #4 sys_clk = ~sys_clk;
    // moved bytes and buffer handoffs seen at the ports
    always @(posedge sys_clk) begin
        if (dma_ack && dma_req_q) acks <= acks + 1;
        if (buf_handoff_q) hands <= hands + 1;
    end
    task chk(input [15:0] got, input [15:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmd(input [7:0] c);
        @(posedge sys_clk);
        cmd_stb <= 1'b1;
        cmd_code <= c;
        @(posedge sys_clk);
        cmd_stb <= 1'b0;
    endtask
    task wr(input [15:0] b);
        @(posedge sys_clk);
        wr_stb <= 1'b1;
        wr_data <= b;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task rd(input [15:0] exp);
        @(posedge sys_clk);
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        chk(rd_data_q, exp);
    endtask
    task put2(input [7:0] c, input [7:0] lo, input [7:0] hi);
        cmd(c);
        wr(lo);
        wr(hi);
    endtask
    task get2(input [7:0] c, input [7:0] lo, input [7:0] hi);
        cmd(c);
        rd(lo);
        rd(hi);
    endtask
    task t_regs;
        cmd(8'hc2);
        wr(8'hff);
        wr(8'hff);
        wr(8'hff);
        wr(8'h00);
        wr(8'hff);
        cmd(8'hc3);
        rd(8'h7f);
        rd(8'hff);
        rd(8'hff);
        rd(8'h00);
        rd(8'h00);
        chk(ep_irq_q, 16'hffff);
        chk({9'h000, bus_irq_q}, 16'h007f);
        put2(8'hf0, 8'hf7, 8'hbf);
        get2(8'hf1, 8'hf3, 8'h80);
    endtask
    task t_dma;
        integer a0, n;
        @(posedge sys_clk);
        hold <= 1'b1;
        put2(8'hf2, 8'h05, 8'h00);
        put2(8'hf0, 8'h29, 8'h80);
        get2(8'hf3, 8'h05, 8'h00);
        @(posedge sys_clk);
        usb_bus_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        usb_bus_rst <= 1'b0;
        get2(8'hf1, 8'h21, 8'h80);
        chk(ep_irq_q, 16'hffff);
        a0 = acks;
        hold <= 1'b0;
        put2(8'hf0, 8'h29, 8'h80);
        n = 0;
        while (transfer_end_q !== 1'b1 && n < 500) begin
            @(posedge sys_clk);
            #1;
            n = n + 1;
        end
        chk({15'h0000, transfer_end_q}, 16'h0001);
        repeat (4) @(posedge sys_clk);
        chk(acks - a0, 16'h0005);
        get2(8'hf3, 8'h00, 8'h00);
        get2(8'hf1, 8'h21, 8'h80);
        cmd(8'h12);
        rd(16'h0005);
    endtask
    task t_eot;
        integer a0, h0, n;
        a0 = acks;
        h0 = hands;
        put2(8'hf0, 8'h2b, 8'h00);
        for (n = 0; n < 900 && acks < a0 + 36; n = n + 1) @(posedge sys_clk);
        hold <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk(hands - h0, 16'h0001);
        dma_eot_ext <= 1'b1;
        @(posedge sys_clk);
        dma_eot_ext <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(hands - h0, 16'h0002);
        get2(8'hf1, 8'h23, 8'h00);
    endtask
    task t_out;
        integer h0;
        h0 = hands;
        cmd(8'h02);
        wr(16'h0002);
        wr(16'h5aa5);
        hold <= 1'b0;
        ep_is_in <= 16'hfffb;
        out_pkt_valid <= 1'b1;
        put2(8'hf0, 8'h29, 8'h40);
        repeat (8) @(posedge sys_clk);
        chk(dma_rdata_q, 16'h005a);
        chk(hands - h0, 16'h0001);
        get2(8'hf3, 8'h03, 8'h00);
        get2(8'hf1, 8'h21, 8'h40);
    endtask
    task t_soft;
        cmd(8'hf6);
        repeat (2) @(posedge sys_clk);
        chk(ep_irq_q, 16'h0000);
        cmd(8'hc3);
        rd(8'h00);
        get2(8'hf1, 8'h00, 8'h00);
    endtask
    task end_of_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // main sequence after sixteen cycles of reset
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs;
        t_dma;
        t_eot;
        t_out;
        t_soft;
        end_of_test;
    end
    // the whole run needs a few hundred cycles, so this only cuts a hang short
    initial begin
        #100000;
        errors = errors + 1;
        end_of_test;
    end
endmodule
bind upd_core upd_core_monitor u_mon (.sys_clk, .rst_n, .usb_bus_rst, .cmd_stb, .cmd_code, .rd_stb, .rd_data_q,
    .ep_evt, .bus_evt, .dma_eot_ext, .dma_req_q, .transfer_end_q, .ep_irq_q, .bus_irq_q);
